// *** core/ire_dev.sv ***
// Purpose: Target end, RAM registers with copy to nonvolatile store
// Assumes: Link lines synchronous to clk_i, controller keeps its timing
// Notes:   Nonvolatile array has no reset
//
// The local read port, not a Wishbone slave, was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module ire_dev (
  // Clock, reset, enable
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // Serial link
  ire_if.dev              link,
  // Local read port
  input  wire logic [7:0] cfg_addr_i,
  output logic      [7:0] cfg_data_o,
  output logic            copy_busy_o
);
  // ****************************************
  // Storage and state
  // ****************************************
  logic [7:0]                  ram_q [0:ire_pkg::RAM_DEPTH-1];
  logic [7:0]                  ee_q  [0:ire_pkg::RAM_DEPTH-1];
  ire_pkg::ire_dst_e           st_q;
  logic                        scl_q;
  logic                        sda_q;
  logic [2:0]                  bc_q;
  logic [7:0]                  sh_q;
  logic                        full_q;
  logic [1:0]                  idx_q;
  logic                        rw_q;
  logic                        ack_q;
  logic [7:0]                  ptr_q;
  logic                        sda_oe_n_q;
  logic                        src_q;
  logic                        copy_q;
  logic [ire_pkg::IDX_W-1:0]   cidx_q;
  logic [7:0]                  cfg_q;
  logic                        scl_rise;
  logic                        scl_fall;
  logic                        start_c;
  logic                        stop_c;
  logic                        byte_done;
  logic                        wr_en;
  logic                        ctrl_we;
  logic [7:0]                  rd_cur;
  logic [7:0]                  rd_nxt;

  // ****************************************
  // Line events
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end else if (ce_i) begin
      scl_q <= link.scl;
      sda_q <= link.sda;
    end
  end

  assign scl_rise  = link.scl & ~scl_q;
  assign scl_fall  = ~link.scl & scl_q;
  assign start_c   = link.scl & scl_q & sda_q & ~link.sda;
  assign stop_c    = link.scl & scl_q & ~sda_q & link.sda;
  assign byte_done = (st_q == ire_pkg::DS_RX) & scl_fall & full_q;
  assign wr_en     = byte_done & (idx_q == 2'h2);
  assign ctrl_we   = wr_en & (ptr_q == ire_pkg::REG_CTRL);

  // ****************************************
  // Read data selection
  // ****************************************
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    rd_byte = 8'h00;
    if (a == ire_pkg::REG_CTRL) begin
      rd_byte = {copy_q, 6'h00, src_q};
    end else if (a < ire_pkg::RAM_DEPTH) begin
      rd_byte = src_q ? ee_q[a[ire_pkg::IDX_W-1:0]] : ram_q[a[ire_pkg::IDX_W-1:0]];
    end
  endfunction

  assign rd_cur = rd_byte(ptr_q);
  assign rd_nxt = rd_byte(ptr_q + 8'h01);

  // ****************************************
  // Byte engine
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q       <= ire_pkg::DS_IDLE;
      bc_q       <= 3'h0;
      sh_q       <= 8'h00;
      full_q     <= 1'h0;
      idx_q      <= 2'h0;
      rw_q       <= 1'h0;
      ack_q      <= 1'h0;
      ptr_q      <= 8'h00;
      sda_oe_n_q <= 1'h1;
    end else if (ce_i) begin
      if (start_c) begin
        st_q       <= ire_pkg::DS_RX;
        bc_q       <= 3'h0;
        full_q     <= 1'h0;
        idx_q      <= 2'h0;
        sda_oe_n_q <= 1'h1;
      end else if (stop_c) begin
        st_q       <= ire_pkg::DS_IDLE;
        sda_oe_n_q <= 1'h1;
      end else begin
        unique case (st_q)
          ire_pkg::DS_IDLE: begin
            sda_oe_n_q <= 1'h1;
          end
          ire_pkg::DS_RX: begin
            if (scl_rise) begin
              sh_q   <= {sh_q[6:0], link.sda};
              bc_q   <= bc_q + 3'h1;
              full_q <= (bc_q == 3'h7);
            end
            if (byte_done) begin
              full_q <= 1'h0;
              if (idx_q == 2'h0) begin
                if (sh_q[7:1] == ire_pkg::TGT_ADDR) begin
                  rw_q       <= sh_q[0];
                  st_q       <= ire_pkg::DS_ACK;
                  sda_oe_n_q <= 1'h0;
                  idx_q      <= 2'h1;
                end else begin
                  st_q <= ire_pkg::DS_IDLE;
                end
              end else begin
                st_q       <= ire_pkg::DS_ACK;
                sda_oe_n_q <= 1'h0;
                idx_q      <= 2'h2;
                if (idx_q == 2'h1) begin
                  ptr_q <= sh_q;
                end else begin
                  ptr_q <= ptr_q + 8'h01;
                end
              end
            end
          end
          ire_pkg::DS_ACK: begin
            if (scl_fall) begin
              bc_q <= 3'h0;
              if (rw_q) begin
                st_q       <= ire_pkg::DS_TX;
                sh_q       <= rd_cur;
                sda_oe_n_q <= rd_cur[7];
              end else begin
                st_q       <= ire_pkg::DS_RX;
                sda_oe_n_q <= 1'h1;
              end
            end
          end
          ire_pkg::DS_TX: begin
            if (scl_fall) begin
              if (bc_q == 3'h7) begin
                st_q       <= ire_pkg::DS_TACK;
                sda_oe_n_q <= 1'h1;
              end else begin
                sda_oe_n_q <= sh_q[6];
                sh_q       <= {sh_q[6:0], 1'h0};
                bc_q       <= bc_q + 3'h1;
              end
            end
          end
          ire_pkg::DS_TACK: begin
            if (scl_rise) begin
              ack_q <= ~link.sda;
            end
            if (scl_fall) begin
              if (ack_q) begin
                ptr_q      <= ptr_q + 8'h01;
                sh_q       <= rd_nxt;
                sda_oe_n_q <= rd_nxt[7];
                bc_q       <= 3'h0;
                st_q       <= ire_pkg::DS_TX;
              end else begin
                st_q <= ire_pkg::DS_IDLE;
              end
            end
          end
          default: begin
            st_q       <= ire_pkg::DS_IDLE;
            sda_oe_n_q <= 1'h1;
          end
        endcase
      end
    end
  end

  // ****************************************
  // RAM registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < ire_pkg::RAM_DEPTH; i++) begin
        ram_q[i] <= 8'h00;
      end
    end else if (ce_i && wr_en && (ptr_q < ire_pkg::RAM_DEPTH)) begin
      ram_q[ptr_q[ire_pkg::IDX_W-1:0]] <= sh_q;
    end
  end

  // ****************************************
  // Control register and copy sequencer
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_q  <= ire_pkg::CTRL_RST[ire_pkg::CTRL_SRC];
      copy_q <= ire_pkg::CTRL_RST[ire_pkg::CTRL_COPY];
      cidx_q <= '0;
    end else if (ce_i) begin
      if (ctrl_we) begin
        src_q <= sh_q[ire_pkg::CTRL_SRC];
      end
      if (ctrl_we && sh_q[ire_pkg::CTRL_COPY]) begin
        copy_q <= 1'h1;
        cidx_q <= '0;
      end else if (copy_q) begin
        cidx_q <= cidx_q + 6'h01;
        if (cidx_q == ire_pkg::RAM_LAST) begin
          copy_q <= 1'h0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i && !rst_i && copy_q) begin
      ee_q[cidx_q] <= ram_q[cidx_q];
    end
  end

  // ****************************************
  // Local read port and outputs
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= 8'h00;
    end else if (ce_i) begin
      cfg_q <= (cfg_addr_i < ire_pkg::RAM_DEPTH) ?
               ram_q[cfg_addr_i[ire_pkg::IDX_W-1:0]] : 8'h00;
    end
  end

  assign cfg_data_o      = cfg_q;
  assign copy_busy_o     = copy_q;
  assign link.sda_d_o    = 1'h0;
  assign link.sda_d_oe_n = sda_oe_n_q;
endmodule // ire_dev
`default_nettype wire

// *** core/ire_host.sv ***
// Purpose: Controller end, byte commands from Wishbone registers
// Assumes: Classic Wishbone master, target never stretches for long
// Notes:   Start, byte and stop of one command run in that order
`timescale 1ns/1ns
`default_nettype none
module ire_host (
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone slave
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Serial link
  ire_if.host              link
);
  ire_pkg::ire_hst_e         st_q;
  logic [ire_pkg::CMD_W-1:0] pend_q;
  logic [7:0]                tx_q;
  logic [7:0]                rx_q;
  logic [7:0]                sh_q;
  logic                      acked_q;
  logic [1:0]                ph_q;
  logic [3:0]                bc_q;
  logic [7:0]                cnt_q;
  logic                      scl_oe_n_q;
  logic                      sda_oe_n_q;
  logic                      ack_q;
  logic [31:0]               dat_q;
  logic                      req;
  logic                      busy;
  logic                      cmd_we;
  logic                      tick;
  logic                      wr_op;
  logic [7:0]                ld_val;
  logic                      nxt_bit;

  // ****************************************
  // Register bus
  // ****************************************
  assign req    = wb_cyc_i & wb_stb_i & ~ack_q;
  assign busy   = (st_q != ire_pkg::HS_IDLE) | (|pend_q[ire_pkg::CMD_RD:0]);
  assign cmd_we = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == ire_pkg::OFS_CMD) & ~busy;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'h0;
      dat_q <= 32'h0000_0000;
      tx_q  <= 8'h00;
    end else if (ce_i) begin
      ack_q <= req;
      if (req && wb_we_i && wb_sel_i[0] && (wb_adr_i == ire_pkg::OFS_TX)) begin
        tx_q <= wb_dat_i[7:0];
      end
      if (req) begin
        unique case (wb_adr_i)
          ire_pkg::OFS_CMD:  dat_q <= {25'h0, pend_q};
          ire_pkg::OFS_TX:   dat_q <= {24'h0, tx_q};
          ire_pkg::OFS_RX:   dat_q <= {24'h0, rx_q};
          ire_pkg::OFS_STAT: dat_q <= {30'h0, acked_q, busy};
          default:           dat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************
  // Bit engine
  // ****************************************
  assign tick    = (cnt_q == 8'h00) & ~((ph_q == 2'h1) & ~link.scl);
  assign wr_op   = pend_q[ire_pkg::CMD_WR];
  assign ld_val  = pend_q[ire_pkg::CMD_ADDR] ?
                   {ire_pkg::TGT_ADDR, pend_q[ire_pkg::CMD_RW]} : tx_q;
  assign nxt_bit = (bc_q == 4'h7) ? (wr_op | pend_q[ire_pkg::CMD_NACK])
                                  : (~wr_op | sh_q[7]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q       <= ire_pkg::HS_IDLE;
      pend_q     <= '0;
      rx_q       <= 8'h00;
      sh_q       <= 8'h00;
      acked_q    <= 1'h0;
      ph_q       <= 2'h0;
      bc_q       <= 4'h0;
      cnt_q      <= 8'h00;
      scl_oe_n_q <= 1'h1;
      sda_oe_n_q <= 1'h1;
    end else if (ce_i) begin
      if (cmd_we) begin
        pend_q <= wb_dat_i[ire_pkg::CMD_W-1:0];
      end
      if (st_q != ire_pkg::HS_IDLE) begin
        cnt_q <= (cnt_q == 8'h00) ? cnt_q : cnt_q - 8'h01;
        if (tick) begin
          cnt_q <= ire_pkg::QTR_CYC - 8'h01;
          ph_q  <= ph_q + 2'h1;
        end
      end
      unique case (st_q)
        ire_pkg::HS_IDLE: begin
          ph_q  <= 2'h0;
          cnt_q <= ire_pkg::QTR_CYC - 8'h01;
          bc_q  <= 4'h0;
          if (pend_q[ire_pkg::CMD_START]) begin
            st_q       <= ire_pkg::HS_START;
            sda_oe_n_q <= 1'h1;
          end else if (pend_q[ire_pkg::CMD_WR] || pend_q[ire_pkg::CMD_RD]) begin
            st_q       <= ire_pkg::HS_BYTE;
            sh_q       <= ld_val;
            sda_oe_n_q <= ~wr_op | ld_val[7];
          end else if (pend_q[ire_pkg::CMD_STOP]) begin
            st_q       <= ire_pkg::HS_STOP;
            sda_oe_n_q <= 1'h0;
          end
        end
        ire_pkg::HS_START: begin
          if (tick) begin
            unique case (ph_q)
              2'h0: scl_oe_n_q <= 1'h1;
              2'h1: sda_oe_n_q <= 1'h0;
              2'h2: scl_oe_n_q <= 1'h0;
              2'h3: begin
                st_q                      <= ire_pkg::HS_IDLE;
                pend_q[ire_pkg::CMD_START] <= 1'h0;
              end
            endcase
          end
        end
        ire_pkg::HS_BYTE: begin
          if (tick) begin
            unique case (ph_q)
              2'h0: scl_oe_n_q <= 1'h1;
              2'h1: begin
                if (bc_q == ire_pkg::ACK_SLOT) begin
                  acked_q <= ~link.sda;
                end else begin
                  sh_q <= {sh_q[6:0], link.sda};
                end
              end
              2'h2: scl_oe_n_q <= 1'h0;
              2'h3: begin
                if (bc_q == ire_pkg::ACK_SLOT) begin
                  st_q                    <= ire_pkg::HS_IDLE;
                  sda_oe_n_q              <= 1'h1;
                  pend_q[ire_pkg::CMD_WR] <= 1'h0;
                  pend_q[ire_pkg::CMD_RD] <= 1'h0;
                  if (!wr_op) begin
                    rx_q <= sh_q;
                  end
                end else begin
                  bc_q       <= bc_q + 4'h1;
                  sda_oe_n_q <= nxt_bit;
                end
              end
            endcase
          end
        end
        ire_pkg::HS_STOP: begin
          if (tick) begin
            unique case (ph_q)
              2'h0: scl_oe_n_q <= 1'h1;
              2'h1: sda_oe_n_q <= 1'h1;
              2'h2: sda_oe_n_q <= 1'h1;
              2'h3: begin
                st_q                     <= ire_pkg::HS_IDLE;
                pend_q[ire_pkg::CMD_STOP] <= 1'h0;
              end
            endcase
          end
        end
        default: begin
          st_q       <= ire_pkg::HS_IDLE;
          scl_oe_n_q <= 1'h1;
          sda_oe_n_q <= 1'h1;
        end
      endcase
    end
  end

  assign wb_ack_o        = ack_q;
  assign wb_dat_o        = dat_q;
  assign link.scl_h_o    = 1'h0;
  assign link.scl_h_oe_n = scl_oe_n_q;
  assign link.sda_h_o    = 1'h0;
  assign link.sda_h_oe_n = sda_oe_n_q;
endmodule // ire_host
`default_nettype wire

// *** include/ire_if.sv ***
// Purpose: Two-wire link between controller and target
// Assumes: Pull-ups on both lines
// Notes:   Line level resolved from the open-drain enables
`timescale 1ns/1ns
`default_nettype none
interface ire_if;
  logic scl;
  logic sda;
  logic scl_h_o;
  logic scl_h_oe_n;
  logic sda_h_o;
  logic sda_h_oe_n;
  logic sda_d_o;
  logic sda_d_oe_n;
  assign scl = scl_h_oe_n | scl_h_o;
  assign sda = (sda_h_oe_n | sda_h_o) & (sda_d_oe_n | sda_d_o);
  modport dev (input scl, input sda, output sda_d_o, output sda_d_oe_n);
  modport host (input scl, input sda, output scl_h_o, output scl_h_oe_n,
                output sda_h_o, output sda_h_oe_n);
endinterface
`default_nettype wire

// *** include/ire_pkg.sv ***
// Purpose: Constants shared by both ends of the register access link
// Assumes: 100 MHz system clock, open-drain two-wire link
// Notes:   Target register map plus controller command layout
`default_nettype none
package ire_pkg;
  // ****************************************
  // Target device map
  // ****************************************
  localparam logic [6:0] TGT_ADDR  = 7'h74;
  localparam logic [7:0] REG_CTRL  = 8'hFF;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam int         CTRL_COPY = 7;
  localparam int         CTRL_SRC  = 0;
  localparam logic [7:0] RAM_DEPTH = 8'h28;
  localparam int         IDX_W     = 6;
  localparam logic [5:0] RAM_LAST  = 6'h27;
  // ****************************************
  // Controller timing and registers
  // ****************************************
  localparam int         CLK_NS    = 10;
  localparam int         SCL_NS    = 4000;
  localparam logic [7:0] QTR_CYC   = 8'(SCL_NS / (4 * CLK_NS));
  localparam logic [3:0] ACK_SLOT  = 4'h8;
  localparam logic [3:0] OFS_CMD   = 4'h0;
  localparam logic [3:0] OFS_TX    = 4'h4;
  localparam logic [3:0] OFS_RX    = 4'h8;
  localparam logic [3:0] OFS_STAT  = 4'hC;
  localparam int         CMD_START = 0;
  localparam int         CMD_STOP  = 1;
  localparam int         CMD_WR    = 2;
  localparam int         CMD_RD    = 3;
  localparam int         CMD_NACK  = 4;
  localparam int         CMD_ADDR  = 5;
  localparam int         CMD_RW    = 6;
  localparam int         CMD_W     = 7;
  // ****************************************
  // State encodings
  // ****************************************
  typedef enum logic [4:0] {
    DS_IDLE = 5'h01,
    DS_RX   = 5'h02,
    DS_ACK  = 5'h04,
    DS_TX   = 5'h08,
    DS_TACK = 5'h10
  } ire_dst_e;
  typedef enum logic [3:0] {
    HS_IDLE  = 4'h1,
    HS_START = 4'h2,
    HS_BYTE  = 4'h4,
    HS_STOP  = 4'h8
  } ire_hst_e;
endpackage
`default_nettype wire

// *** testbench/ire_link_properties.sv ***
// Purpose: Link checker beside the interface joining both ends
// Assumes: Lines sampled on clk_i, synchronous reset
// Notes:   Decodes bytes and ack slots from the lines
`timescale 1ns/1ns
`default_nettype none
module ire_link_properties (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Link lines
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic scl_h_o,
  input  wire logic scl_h_oe_n,
  input  wire logic sda_h_o,
  input  wire logic sda_h_oe_n,
  input  wire logic sda_d_o,
  input  wire logic sda_d_oe_n
);
  // ******
  // Decode
  // ******
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic       first_q;
  logic       rd_q;
  logic       nack_q;
  logic       rise;
  logic       start;
  assign rise  = scl & ~scl_q;
  assign start = scl & scl_q & sda_q & ~sda;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bit_q   <= 4'h0;
      sh_q    <= 8'h00;
      first_q <= 1'b1;
      rd_q    <= 1'b0;
      nack_q  <= 1'b0;
    end else if (start) begin
      bit_q   <= 4'h0;
      first_q <= 1'b1;
      nack_q  <= 1'b0;
    end else if (rise && bit_q == 4'h8) begin
      bit_q   <= 4'h0;
      first_q <= 1'b0;
      nack_q  <= !first_q && rd_q && sda;
      if (first_q)
        rd_q <= sh_q[0];
    end else if (rise) begin
      bit_q <= bit_q + 4'h1;
      sh_q  <= {sh_q[6:0], sda};
    end
  end
  // **********
  // Properties
  // **********
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_addr_ack;
    rise && bit_q == 4'h8 && first_q && sh_q[7:1] == ire_pkg::TGT_ADDR |-> !sda [*8];
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("Target address not acknowledged");
  property p_wr_ack;
    rise && bit_q == 4'h8 && !first_q && !rd_q |-> !sda;
  endproperty
  a_wr_ack: assert property (p_wr_ack)
    else $error("Written byte not acknowledged");
  property p_rd_release;
    rise && bit_q == 4'h8 && !first_q && rd_q |-> sda_d_oe_n;
  endproperty
  a_rd_release: assert property (p_rd_release)
    else $error("Target holds line in read ack slot");
  property p_rd_host;
    rise && bit_q < 4'h8 && !first_q && rd_q && !nack_q |-> sda_h_oe_n;
  endproperty
  a_rd_host: assert property (p_rd_host)
    else $error("Controller drives read data bit");
  property p_wr_quiet;
    rise && bit_q < 4'h8 && (first_q || !rd_q) |-> sda_d_oe_n;
  endproperty
  a_wr_quiet: assert property (p_wr_quiet)
    else $error("Target drives a written bit");
  property p_dev_edge;
    $changed(sda_d_oe_n) |-> !scl;
  endproperty
  a_dev_edge: assert property (p_dev_edge)
    else $error("Target changed data while clock high");
  property p_rd_stable;
    rise && bit_q < 4'h8 && !first_q && rd_q && !nack_q |-> $stable(sda) [*8];
  endproperty
  a_rd_stable: assert property (p_rd_stable)
    else $error("Read data bit moved while clock high");
  property p_wr_stable;
    rise && bit_q < 4'h8 && (first_q || !rd_q) |-> $stable(sda) [*8];
  endproperty
  a_wr_stable: assert property (p_wr_stable)
    else $error("Written bit moved while clock high");
  c_addr: cover property (rise && bit_q == 4'h8 && first_q && !sda);
  c_wr: cover property (rise && bit_q == 4'h8 && !first_q && !rd_q);
  c_nack: cover property (rise && bit_q == 4'h8 && !first_q && rd_q && sda);
endmodule // ire_link_properties
`default_nettype wire

// *** testbench/testbench.sv ***
// Purpose: Both ends joined, driven over Wishbone
// Assumes: Full speed link timing from the package
// Notes:   Local read port checks RAM contents
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct {logic [7:0] a; logic [7:0] e;} ire_row_s;
  logic        clk_i;
  logic        rst_i;
  logic [3:0]  wb_adr;
  logic [31:0] wb_wd;
  logic        wb_we;
  logic        wb_cyc;
  logic [31:0] wb_rd;
  logic        wb_ack;
  logic [7:0]  cfg_addr;
  logic [7:0]  cfg_data;
  logic        copy_busy;
  logic [31:0] st;
  int          errors;
  int          check_count;
  int          busy_run;
  int          busy_len;
  ire_row_s    rows [6] = '{'{8'h00, 8'hA5}, '{8'h01, 8'h3C}, '{8'h02, 8'h00},
                            '{8'h27, 8'h00}, '{8'h28, 8'h00}, '{8'hFF, 8'h00}};
  ire_if link_if ();
  ire_dev i_ire_dev (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .link(link_if),
    .cfg_addr_i(cfg_addr), .cfg_data_o(cfg_data), .copy_busy_o(copy_busy));
  ire_host i_ire_host (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_adr_i(wb_adr),
    .wb_dat_i(wb_wd), .wb_sel_i(4'hF), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_cyc), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .link(link_if));
  ire_link_properties i_ire_link_properties (.clk_i(clk_i), .rst_i(rst_i),
    .scl(link_if.scl), .sda(link_if.sda), .scl_h_o(link_if.scl_h_o),
    .scl_h_oe_n(link_if.scl_h_oe_n), .sda_h_o(link_if.sda_h_o),
    .sda_h_oe_n(link_if.sda_h_oe_n), .sda_d_o(link_if.sda_d_o),
    .sda_d_oe_n(link_if.sda_d_oe_n));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Length of the last copy pulse
  always @(posedge clk_i) begin
    if (copy_busy === 1'b1)
      busy_run <= busy_run + 1;
    else if (busy_run != 0) begin
      busy_len <= busy_run;
      busy_run <= 0;
    end
  end
  task automatic give_verdict();
    $display("Counts: %0d checks, %0d errors", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb_xfer(input logic [3:0] a, input logic we, input logic [31:0] d,
                         output logic [31:0] r);
    int n;
    @(posedge clk_i);
    wb_adr <= a;
    wb_we  <= we;
    wb_wd  <= d;
    wb_cyc <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 100);
    r = wb_rd;
    wb_cyc <= 1'b0;
    wb_we  <= 1'b0;
    if (n >= 100) begin
      errors++;
      give_verdict();
    end
  endtask
  // Command bits: 01 start, 02 stop, 04 write, 08 read, 10 nack, 20 addr, 40 rw
  task automatic cmd(input logic [7:0] tx, input logic [7:0] c);
    int n;
    wb_xfer(ire_pkg::OFS_TX, 1'b1, {24'h0, tx}, st);
    wb_xfer(ire_pkg::OFS_CMD, 1'b1, {24'h0, c}, st);
    n = 0;
    do begin
      wb_xfer(ire_pkg::OFS_STAT, 1'b0, 32'h0, st);
      n++;
    end while (st[0] !== 1'b0 && n < 6000);
    if (n >= 6000) begin
      errors++;
      give_verdict();
    end
  endtask
  initial begin
    rst_i    = 1'b1;
    wb_adr   = 4'h0;
    wb_wd    = 32'h0;
    wb_we    = 1'b0;
    wb_cyc   = 1'b0;
    cfg_addr = 8'h00;
    errors   = 0;
    check_count = 0;
    busy_run = 0;
    busy_len = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset and register access
    wb_xfer(ire_pkg::OFS_STAT, 1'b0, 32'h0, st);
    check(st, 32'h0);
    wb_xfer(4'h2, 1'b0, 32'h0, st);
    check(st, 32'h0);
    wb_xfer(ire_pkg::OFS_TX, 1'b1, 32'h5A, st);
    wb_xfer(ire_pkg::OFS_TX, 1'b0, 32'h0, st);
    check(st, 32'h5A);
    $display("Test reset done");
    // Copy zero RAM to store and select store
    cmd(8'hE8, 8'h25);
    check(st[1], 1'b1);
    cmd(ire_pkg::REG_CTRL, 8'h04);
    check(st[1], 1'b1);
    cmd(8'h81, 8'h06);
    check(st[1], 1'b1);
    check(busy_len, 32'd40);
    $display("Test copy done");
    // Burst write with auto increment
    cmd(8'hE8, 8'h25);
    cmd(8'h00, 8'h04);
    cmd(8'hA5, 8'h04);
    check(st[1], 1'b1);
    cmd(8'h3C, 8'h06);
    check(st[1], 1'b1);
    foreach (rows[i]) begin
      @(posedge clk_i);
      cfg_addr <= rows[i].a;
      repeat (2) @(posedge clk_i);
      check(cfg_data, rows[i].e);
    end
    $display("Test burst write done");
    // Read control then wrap to store location zero
    cmd(8'hE8, 8'h25);
    cmd(ire_pkg::REG_CTRL, 8'h04);
    cmd(8'hE9, 8'h65);
    check(st[1], 1'b1);
    cmd(8'h00, 8'h08);
    wb_xfer(ire_pkg::OFS_RX, 1'b0, 32'h0, st);
    check(st[7:0], 8'h01);
    cmd(8'h00, 8'h1A);
    wb_xfer(ire_pkg::OFS_RX, 1'b0, 32'h0, st);
    check(st[7:0], 8'h00);
    $display("Test read done");
    // Select RAM and read two registers
    cmd(8'hE8, 8'h25);
    cmd(ire_pkg::REG_CTRL, 8'h04);
    cmd(8'h00, 8'h06);
    check(st[1], 1'b1);
    cmd(8'hE8, 8'h25);
    cmd(8'h00, 8'h04);
    cmd(8'hE9, 8'h65);
    cmd(8'h00, 8'h08);
    wb_xfer(ire_pkg::OFS_RX, 1'b0, 32'h0, st);
    check(st[7:0], 8'hA5);
    cmd(8'h00, 8'h1A);
    wb_xfer(ire_pkg::OFS_RX, 1'b0, 32'h0, st);
    check(st[7:0], 8'h3C);
    $display("Test RAM read done");
    // Reset in mid-run clears RAM and receive data
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i    <= 1'b0;
    cfg_addr <= 8'h00;
    repeat (2) @(posedge clk_i);
    check(cfg_data, 8'h00);
    wb_xfer(ire_pkg::OFS_RX, 1'b0, 32'h0, st);
    check(st, 32'h0);
    $display("Test mid-run reset done");
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
